/* ptg_gear.sv */
// probe triggered gearing, input polarity and periodic host interrupt
`timescale 1ns/1ps
`default_nettype none

module ptg_gear
    import ptg_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input  wire logic               i_clock,
    input  wire logic               i_rst,
    input  wire logic               i_cmd_valid,
    input  wire ptg_cmd_t           i_cmd,
    input  wire logic [31:0]        i_din,
    input  wire logic               i_servo_tick,
    input  wire logic signed [15:0] i_master_delta,
    input  wire logic               i_master_stopped,
    output logic                    o_cmd_err,
    output logic                    o_engaged,
    output logic                    o_armed,
    output logic                    o_master_halt,
    output logic                    o_slave_halt,
    output logic [2:0]              o_master_axis,
    output logic [2:0]              o_slave_axis,
    output logic [23:0]             o_slave_delta,
    output logic [31:0]             o_active,
    output logic                    o_mem_we,
    output logic [12:0]             o_mem_addr,
    output logic [7:0]              o_mem_data,
    output logic                    o_host_irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] level_active(input logic [31:0] lvl, input logic [31:0] pol);
        level_active = ~(lvl ^ pol) & INP_MASK;
    endfunction : level_active

    ptg_regs_t s;
    ptg_regs_t n;

    logic [31:0]        act_now;
    logic [31:0]        rise;
    logic [PROBE_CNT-1:0] probe_rise;
    logic               sel_ok;
    logic               tick_fire;
    logic               take_tick;
    logic               take_probe;
    logic signed [31:0] product;

    assign act_now    = level_active(s.din_q2, s.pol);
    assign rise       = act_now & ~s.act;
    assign probe_rise = rise[PROBE_BASE +: PROBE_CNT];
    assign sel_ok     = (i_cmd.sel != 3'h0) && (i_cmd.sel <= 3'(PROBE_CNT));
    assign tick_fire  = s.tick_en && (s.tick_cnt == TICK_W'(TICK_CYCLES - 1));
    assign take_tick  = (s.wph == 2'h0) && s.pend_tick;
    assign take_probe = (s.wph == 2'h0) && !s.pend_tick && s.pend_probe;
    assign product    = i_master_delta * $signed(s.ratio);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n          = s;
        n.din_q1   = i_din;
        n.din_q2   = s.din_q1;
        n.act      = act_now;
        n.cmd_err  = 1'b0;
        n.mem_we   = 1'b0;
        n.irq      = 1'b0;

        // commands from the host
        if (i_cmd_valid) begin
            case (i_cmd.code)
                C_NOP: ;
                C_GEAR_PROBE: begin
                    n.probe_ie = 1'b0;
                    if (sel_ok) begin
                        n.st     = S_ARMED;
                        n.master = i_cmd.master;
                        n.slave  = i_cmd.slave;
                        n.sel    = 2'(i_cmd.sel - 3'h1);
                        n.ratio  = i_cmd.ratio;
                    end else begin
                        n.cmd_err = 1'b1;
                    end
                end
                C_GEAR_OFF: begin
                    n.st          = S_IDLE;
                    n.master_halt = 1'b0;
                    n.slave_halt  = 1'b0;
                end
                C_INP_STATE: begin
                    if (32'(i_cmd.index) < INP_CNT) begin
                        n.pol[i_cmd.index] = i_cmd.value;
                    end else begin
                        n.cmd_err = 1'b1;
                    end
                end
                C_TICK_EN:  n.tick_en  = i_cmd.value;
                C_PROBE_IE: n.probe_ie = i_cmd.value;
                default:    n.cmd_err  = 1'b1;
            endcase
        end

        // gearing sequence
        if (!(i_cmd_valid && (i_cmd.code == C_GEAR_PROBE || i_cmd.code == C_GEAR_OFF))) begin
            case (s.st)
                S_IDLE: ;
                S_ARMED: begin
                    if (probe_rise[s.sel]) begin
                        n.st = S_TRIG;
                    end
                end
                S_TRIG: begin
                    if (i_servo_tick) begin
                        n.st = S_ENG;
                    end
                end
                S_ENG: begin
                    if (act_now[EMERGENCY_STOP_INPUT_IDX]) begin
                        n.st          = S_HALT_M;
                        n.master_halt = 1'b1;
                    end
                end
                S_HALT_M: begin
                    if (i_master_stopped) begin
                        n.st         = S_HALT_S;
                        n.slave_halt = 1'b1;
                    end
                end
                S_HALT_S: ;
                default: n.st = S_IDLE;
            endcase
        end

        // registered status decodes of the next state
        n.engaged = (n.st == S_ENG) || (n.st == S_HALT_M) || (n.st == S_HALT_S);
        n.armed   = (n.st == S_ARMED) || (n.st == S_TRIG);

        // slave motion command
        if (s.st != S_ENG) begin
            n.slave_delta = 24'h00_0000;
        end else if (i_servo_tick) begin
            n.slave_delta = product[RATIO_FRAC +: 24];
        end

        // periodic timer
        if (!s.tick_en || tick_fire) begin
            n.tick_cnt = '0;
        end else begin
            n.tick_cnt = s.tick_cnt + TICK_W'(1);
        end

        // pending host events, a new event wins over its own service
        n.pend_tick  = (s.pend_tick && !take_tick) || tick_fire;
        n.pend_probe = (s.pend_probe && !take_probe)
                     || (s.probe_ie && (s.st == S_IDLE) && (|probe_rise));

        // shared memory writer and host interrupt
        case (s.wph)
            2'h0: begin
                if (take_tick || take_probe) begin
                    n.wph      = 2'h1;
                    n.cur_tick = take_tick;
                    n.mem_we   = 1'b1;
                    n.mem_addr = CAUSE_ADDR;
                    n.mem_data = take_tick ? CAUSE_TICK : CAUSE_PROBE;
                end
            end
            2'h1: begin
                if (s.cur_tick) begin
                    n.wph      = 2'h2;
                    n.mem_we   = 1'b1;
                    n.mem_addr = STATUS_ADDR;
                    n.mem_data = TICK_FLAG;
                end else begin
                    n.wph = 2'h0;
                    n.irq = 1'b1;
                end
            end
            2'h2: begin
                n.wph = 2'h0;
                n.irq = 1'b1;
            end
            default: n.wph = 2'h0;
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s      <= '0;
            s.st   <= S_IDLE;
            s.pol  <= POL_RST;
            // sync flops start at the inactive level, so no false rise follows reset
            s.din_q1 <= ~POL_RST;
            s.din_q2 <= ~POL_RST;
        end else begin
            s <= n;
        end
    end

    assign o_cmd_err     = s.cmd_err;
    assign o_engaged     = s.engaged;
    assign o_armed       = s.armed;
    assign o_master_halt = s.master_halt;
    assign o_slave_halt  = s.slave_halt;
    assign o_master_axis = s.master;
    assign o_slave_axis  = s.slave;
    assign o_slave_delta = s.slave_delta;
    assign o_active      = s.act;
    assign o_mem_we      = s.mem_we;
    assign o_mem_addr    = s.mem_addr;
    assign o_mem_data    = s.mem_data;
    assign o_host_irq    = s.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    a_reset_pol_low: assert property ($past(i_rst) |-> s.pol == POL_RST)
        else $error("polarity not active low after reset");

    a_gear_clears_ie: assert property (i_cmd_valid && i_cmd.code == C_GEAR_PROBE |=> !s.probe_ie)
        else $error("probe interrupt enable survived gearing command");

    a_probe_irq_quiet: assert property ($rose(s.pend_probe) |-> $past(s.st) == S_IDLE)
        else $error("probe interrupt raised while gearing pending");

    a_bad_selector: assert property (i_cmd_valid && i_cmd.code == C_GEAR_PROBE && !sel_ok |=> o_cmd_err && $stable(s.st))
        else $error("invalid probe selector accepted");

    a_engage_next_tick: assert property (s.st == S_TRIG && i_servo_tick && !i_cmd_valid |=> o_engaged ##1 !o_armed)
        else $error("gearing not engaged on control tick");

    a_halt_order: assert property ($rose(s.slave_halt) |-> s.master_halt && $past(s.st) == S_HALT_M)
        else $error("slave halted before master");

    a_stay_engaged: assert property (s.st == S_HALT_S && !i_cmd_valid |=> o_engaged && o_slave_halt)
        else $error("slave disengaged after emergency halt");

    a_probe_trigger: assert property (s.st == S_ARMED && probe_rise[s.sel] && !i_cmd_valid |=> s.st == S_TRIG)
        else $error("selected probe activation not taken");

    a_emergency_stop_input_halt: assert property (s.st == S_ENG && act_now[EMERGENCY_STOP_INPUT_IDX] && !i_cmd_valid |=> o_master_halt && o_engaged)
        else $error("emergency stop did not halt the master");

    a_tick_off_quiet: assert property (!s.tick_en && !s.pend_tick |=> !s.pend_tick)
        else $error("periodic event while disabled");

    a_tick_period: assert property (tick_fire |=> s.pend_tick && s.tick_cnt == '0)
        else $error("periodic event not queued");

    a_cause_write: assert property (take_tick |=> o_mem_we && o_mem_addr == CAUSE_ADDR ##1 o_mem_we && o_mem_addr == STATUS_ADDR && o_mem_data[TICK_BIT] ##1 o_host_irq)
        else $error("periodic interrupt write sequence wrong");

endmodule : ptg_gear

`default_nettype wire

/* ptg_pkg.sv */
// constants, commands and state types for probe triggered gearing
package ptg_pkg;

    // ------------------------------------------------------------
    // variant and sizes
    // ------------------------------------------------------------
    localparam bit          LARGE       = 1'b1;
    localparam int          PROBE_CNT   = LARGE ? 4 : 2;
    localparam int          INP_CNT     = LARGE ? 32 : 22;
    localparam int          RATIO_W     = 16;
    localparam int          RATIO_FRAC  = 7;
    localparam int          PROBE_BASE  = 16;
    localparam int          EMERGENCY_STOP_INPUT_IDX   = 20;
    localparam logic [31:0] POL_RST     = 32'h0000_0000;
    localparam logic [31:0] INP_MASK    = LARGE ? 32'hffff_ffff : 32'h003f_ffff;

    // ------------------------------------------------------------
    // shared host memory map and codes
    // ------------------------------------------------------------
    localparam logic [12:0] CAUSE_ADDR  = 13'h0009;
    localparam logic [12:0] STATUS_ADDR = LARGE ? 13'h1ffe : 13'h07fe;
    localparam int          TICK_BIT    = 6;
    localparam logic [7:0]  TICK_FLAG   = 8'h40;
    localparam logic [7:0]  CAUSE_TICK  = 8'h05;
    localparam logic [7:0]  CAUSE_PROBE = 8'h03;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_MHZ     = 100;
    localparam int          TICK_MS     = 5;
    localparam int          TICK_CYC    = TICK_MS * 1000 * CLK_MHZ;
    localparam int          TICK_W      = 20;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        C_NOP = 3'h0, C_GEAR_PROBE = 3'h1, C_GEAR_OFF = 3'h2,
        C_INP_STATE = 3'h3, C_TICK_EN = 3'h4, C_PROBE_IE = 3'h5
    } ptg_cmd_e_t;

    typedef struct packed {
        ptg_cmd_e_t           code;
        logic [2:0]           master;
        logic [2:0]           slave;
        logic [2:0]           sel;
        logic [RATIO_W-1:0]   ratio;
        logic [4:0]           index;
        logic                 value;
    } ptg_cmd_t;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01, S_ARMED = 6'h02, S_TRIG = 6'h04,
        S_ENG = 6'h08, S_HALT_M = 6'h10, S_HALT_S = 6'h20
    } ptg_state_t;

    typedef struct packed {
        ptg_state_t         st;
        logic               engaged;
        logic               armed;
        logic [2:0]         master;
        logic [2:0]         slave;
        logic [1:0]         sel;
        logic [RATIO_W-1:0] ratio;
        logic [31:0]        pol;
        logic [31:0]        din_q1;
        logic [31:0]        din_q2;
        logic [31:0]        act;
        logic               tick_en;
        logic               probe_ie;
        logic [TICK_W-1:0]  tick_cnt;
        logic               pend_tick;
        logic               pend_probe;
        logic [1:0]         wph;
        logic               cur_tick;
        logic               mem_we;
        logic [12:0]        mem_addr;
        logic [7:0]         mem_data;
        logic               irq;
        logic               cmd_err;
        logic               master_halt;
        logic               slave_halt;
        logic [23:0]        slave_delta;
    } ptg_regs_t;

endpackage : ptg_pkg

/* ptg_host_model.sv */
// host side model: shared host memory locations and interrupt counter
`timescale 1ns/1ps
`default_nettype none

module ptg_host_model
    import ptg_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_mem_we,
    input  wire logic [12:0] i_mem_addr,
    input  wire logic [7:0]  i_mem_data,
    input  wire logic        i_host_irq,
    output logic [7:0]       o_cause,
    output logic [7:0]       o_status,
    output logic [7:0]       o_irq_count
);

    // ------------------------------------------------------------
    // shared memory capture
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_cause     <= 8'h00;
            o_status    <= 8'h00;
            o_irq_count <= 8'h00;
        end else begin
            if (i_mem_we && i_mem_addr == CAUSE_ADDR) begin
                o_cause <= i_mem_data;
            end
            if (i_mem_we && i_mem_addr == STATUS_ADDR) begin
                o_status <= i_mem_data;
            end
            if (i_host_irq) begin
                o_irq_count <= o_irq_count + 8'h01;
            end
        end
    end

endmodule : ptg_host_model

`default_nettype wire

/* tb_top.sv */
// self-checking bench for probe triggered gearing
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import ptg_pkg::*;
;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int      TCYC = 50;
    logic               i_clock, i_rst, i_cmd_valid, i_servo_tick, i_master_stopped;
    ptg_cmd_t           i_cmd;
    logic [31:0]        i_din;
    logic signed [15:0] i_master_delta;
    logic               o_cmd_err, o_engaged, o_armed, o_master_halt, o_slave_halt;
    logic [2:0]         o_master_axis, o_slave_axis;
    logic [23:0]        o_slave_delta;
    logic [31:0]        o_active;
    logic               o_mem_we, o_host_irq;
    logic [12:0]        o_mem_addr;
    logic [7:0]         o_mem_data, cause, status, irqs, irq0;
    int                 failures, comparisons, n;
    logic [2:0]         gs;
    logic [15:0]        gr, gd;
    logic [23:0]        ge;
    // row: index, polarity, level, expected activity
    logic [7:0]         pol_rows [7] = '{8'h07, 8'h02, 8'h2c, 8'haf, 8'hf9, 8'hfc, 8'h51};
    // row: selector, ratio, master delta, expected slave delta
    logic [58:0]        gear_rows [5] = '{{3'h1, 16'h0140, 16'h0064, 24'h0000fa},
                                          {3'h2, 16'h8000, 16'hfffd, 24'h000300},
                                          {3'h3, 16'h0001, 16'h0080, 24'h000001},
                                          {3'h4, 16'hffff, 16'h0080, 24'hffffff},
                                          {3'h1, 16'h7fff, 16'h0002, 24'h0001ff}};
    // row: code, selector of refused commands
    logic [5:0]         err_rows [4] = '{6'h08, 6'h0d, 6'h31, 6'h39};

    ptg_gear #(.TICK_CYCLES(TCYC)) ptg_gear_inst (
        .i_clock, .i_rst, .i_cmd_valid, .i_cmd, .i_din, .i_servo_tick, .i_master_delta,
        .i_master_stopped, .o_cmd_err, .o_engaged, .o_armed, .o_master_halt, .o_slave_halt,
        .o_master_axis, .o_slave_axis, .o_slave_delta, .o_active, .o_mem_we, .o_mem_addr,
        .o_mem_data, .o_host_irq
    );

    ptg_host_model ptg_host_model_inst (
        .i_clock, .i_rst, .i_mem_we(o_mem_we), .i_mem_addr(o_mem_addr), .i_mem_data(o_mem_data),
        .i_host_irq(o_host_irq), .o_cause(cause), .o_status(status), .o_irq_count(irqs)
    );

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    task automatic step(input int k);
        repeat (k) @(posedge i_clock);
        #1;
    endtask : step

    task automatic send(input logic [2:0] c, input logic [2:0] s, input logic [15:0] r,
                        input logic [4:0] x, input logic v);
        @(posedge i_clock);
        i_cmd_valid <= 1'h1;
        i_cmd       <= '{code: ptg_cmd_e_t'(c), master: 3'h1, slave: 3'h2, sel: s, ratio: r, index: x, value: v};
        @(posedge i_clock);
        i_cmd_valid <= 1'h0;
        #1;
    endtask : send

    task automatic pin(input int x, input logic v);
        @(posedge i_clock);
        i_din[x] <= v;
        #1;
    endtask : pin

    task automatic servo(input logic [15:0] d);
        @(posedge i_clock);
        i_servo_tick   <= 1'h1;
        i_master_delta <= d;
        @(posedge i_clock);
        i_servo_tick <= 1'h0;
        #1;
    endtask : servo

    task automatic wait_irq(output int cyc);
        cyc = 0;
        do begin
            step(1);
            cyc++;
        end while (o_host_irq !== 1'h1 && cyc < 300);
        if (cyc >= 300) begin
            failures++;
            print_verdict();
        end
    endtask : wait_irq

    // ------------------------------------------------------------
    // clock and main sequence
    // ------------------------------------------------------------
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    initial begin
        {i_rst, i_cmd_valid, i_servo_tick, i_master_stopped} = 4'h8;
        i_cmd = '0;
        i_din = 32'hffff_ffff;
        i_master_delta = 16'h0000;
        failures = 0;
        comparisons = 0;
        repeat (3) @(posedge i_clock);
        i_rst <= 1'h0;
        step(4);
        check(o_active, 32'h0);
        foreach (pol_rows[r]) begin
            send(3'h3, 3'h0, 16'h0, pol_rows[r][7:3], pol_rows[r][2]);
            pin(pol_rows[r][7:3], pol_rows[r][1]);
            step(4);
            check(o_active[pol_rows[r][7:3]], pol_rows[r][0]);
            pin(pol_rows[r][7:3], 1'h1);
        end
        send(3'h5, 3'h0, 16'h0, 5'h00, 1'h1);
        irq0 = irqs;
        foreach (gear_rows[r]) begin
            {gs, gr, gd, ge} = gear_rows[r];
            send(3'h1, gs, gr, 5'h00, 1'h0);
            check({o_armed, o_master_axis, o_slave_axis}, 7'h4a);
            pin(15 + gs, 1'h0);
            step(5);
            servo(16'h0000);
            step(2);
            check({o_engaged, o_armed}, 2'h2);
            servo(gd);
            step(2);
            check(o_slave_delta, ge);
            send(3'h2, 3'h0, 16'h0, 5'h00, 1'h0);
            pin(15 + gs, 1'h1);
            step(4);
        end
        check(irqs, irq0);
        send(3'h1, 3'h1, 16'h0100, 5'h00, 1'h0);
        pin(16, 1'h0);
        step(5);
        servo(16'h0010);
        step(2);
        pin(20, 1'h0);
        step(5);
        check({o_master_halt, o_slave_halt, o_engaged}, 3'h5);
        @(posedge i_clock);
        i_master_stopped <= 1'h1;
        step(3);
        check({o_master_halt, o_slave_halt, o_engaged}, 3'h7);
        send(3'h2, 3'h0, 16'h0, 5'h00, 1'h0);
        pin(20, 1'h1);
        pin(16, 1'h1);
        @(posedge i_clock);
        i_master_stopped <= 1'h0;
        step(4);
        send(3'h5, 3'h0, 16'h0, 5'h00, 1'h1);
        pin(16, 1'h0);
        wait_irq(n);
        check(cause, CAUSE_PROBE);
        pin(16, 1'h1);
        send(3'h4, 3'h0, 16'h0, 5'h00, 1'h1);
        wait_irq(n);
        check(cause, CAUSE_TICK);
        check(status, 8'h40);
        wait_irq(n);
        check(n, TCYC);
        send(3'h4, 3'h0, 16'h0, 5'h00, 1'h0);
        irq0 = irqs;
        step(150);
        check(irqs, irq0);
        foreach (err_rows[r]) begin
            send(err_rows[r][5:3], err_rows[r][2:0], 16'h0100, 5'h00, 1'h0);
            check({o_cmd_err, o_armed}, 2'h2);
        end
        @(posedge i_clock);
        i_rst <= 1'h1;
        repeat (3) @(posedge i_clock);
        i_rst <= 1'h0;
        step(1);
        check({o_engaged, o_mem_we, o_host_irq, o_active}, 35'h0);
        step(4);
        check(o_active, 32'h0);
        print_verdict();
    end

endmodule : tb_top

`default_nettype wire
